// >>> src/nonvolatile_controller.sv
// flash program and erase sequencer with stall, fault and ready outputs
`timescale 1ns/1ns
module nonvolatile_controller #(
  parameter int unsigned PAGE_ERASE_CYCLES   = nvm_ctrl_pkg::PAGE_ERASE_CYC,
  parameter int unsigned FULL_ERASE_CYCLES   = nvm_ctrl_pkg::FULL_ERASE_CYC,
  parameter int unsigned PARTIAL_UNIT_CYCLES = nvm_ctrl_pkg::PARTIAL_UNIT_CYC
) (
  input  wire logic                      MCLK_I,
  input  wire logic                      RESET_N_I,
  input  wire nvm_ctrl_pkg::access_mode_e ACCESS_MODE_I,
  input  wire logic                      STORE_VALID_I,
  input  wire nvm_ctrl_pkg::store_req_s  STORE_REQ_I,
  output logic                           STORE_READY_O,
  input  wire logic                      FETCH_FLASH_I,
  input  wire logic                      PAGE_ERASE_TRIGGER_I,
  input  wire logic                      USER_AREA_ERASE_TRIGGER_I,
  input  wire logic                      FULL_ERASE_TRIGGER_I,
  input  wire logic                      PARTIAL_ERASE_TRIGGER_I,
  input  wire logic [31:0]               ERASE_ADDR_I,
  input  wire logic [6:0]                PARTIAL_ERASE_DURATION_I,
  input  wire logic [31:0]               ARRAY_RDATA_I,
  output nvm_ctrl_pkg::array_cmd_s       ARRAY_CMD_O,
  output logic                           BUS_STALL_O,
  output logic                           HARD_FAULT_O,
  output logic                           READY_O,
  output logic                           USER_CFG_PENDING_O,
  output logic                           PARTIAL_COMPLETE_O
);
  import nvm_ctrl_pkg::*;

  typedef struct packed {
    seq_state_e  st;
    array_cmd_s  cmd;
    logic [31:0] cnt;
    logic        fault;
    logic        cfg_pend;
    logic [31:0] part_addr;
    logic [31:0] part_acc;
  } ctl_s;

  localparam logic [31:0] WRITE_LOAD = 32'(WORD_WRITE_CYC - 1);
  localparam logic [31:0] PAGE_LOAD  = 32'(PAGE_ERASE_CYCLES - 1);
  localparam logic [31:0] FULL_LOAD  = 32'(FULL_ERASE_CYCLES - 1);
  localparam logic [31:0] PAGE_TOTAL = 32'(PAGE_ERASE_CYCLES);

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
    in_range = (a >= base) && ((a - base) < size);
  endfunction : in_range

  function automatic logic [31:0] page_of(input logic [31:0] a);
    page_of = {a[31:12], 12'h000};
  endfunction : page_of

  logic rst_sync1_r;
  logic rst_n;
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync1_r <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_n       <= rst_sync1_r;
    end
  end

  ctl_s q_r;
  ctl_s q_nxt;
  logic store_target;
  logic word_ok;
  logic erase_go;
  logic [31:0] part_load;

  always_comb begin
    store_target = in_range(STORE_REQ_I.addr, FLASH_BASE, FLASH_SIZE) ||
                   in_range(STORE_REQ_I.addr, USER_AREA_BASE, USER_AREA_SIZE);
    word_ok      = (STORE_REQ_I.size == SIZE_WORD) && (STORE_REQ_I.addr[1:0] == 2'b00);
    // mode 3 selects both modes: treated as neither to keep the array safe
    erase_go     = (q_r.st == ST_IDLE) && (ACCESS_MODE_I == MODE_ERASE);
    part_load    = 32'(PARTIAL_ERASE_DURATION_I) * 32'(PARTIAL_UNIT_CYCLES);
    q_nxt        = q_r;
    q_nxt.fault  = 1'b0;
    unique case (q_r.st)
      ST_IDLE: begin
        q_nxt.cmd.op = OP_NONE;
        if (STORE_VALID_I && store_target && !word_ok) begin
          q_nxt.fault = 1'b1;
        end else if (STORE_VALID_I && store_target && ACCESS_MODE_I == MODE_PROGRAM) begin
          q_nxt.st       = ST_PRG_RD;
          q_nxt.cmd.op   = OP_READ;
          q_nxt.cmd.addr = STORE_REQ_I.addr;
          q_nxt.cmd.wdata = STORE_REQ_I.data;
          q_nxt.cfg_pend = q_r.cfg_pend | in_range(STORE_REQ_I.addr, USER_AREA_BASE, USER_AREA_SIZE);
        end else if (erase_go && FULL_ERASE_TRIGGER_I) begin
          // factory area lies outside both ranges and is never addressed
          q_nxt.st       = ST_ERASE;
          q_nxt.cmd.op   = OP_ERASE_ALL;
          q_nxt.cmd.addr = FLASH_BASE;
          q_nxt.cnt      = FULL_LOAD;
          q_nxt.cfg_pend = 1'b1;
          q_nxt.part_acc = 32'h0000_0000;
        end else if (erase_go && USER_AREA_ERASE_TRIGGER_I) begin
          q_nxt.st       = ST_ERASE;
          q_nxt.cmd.op   = OP_ERASE_USER;
          q_nxt.cmd.addr = USER_AREA_BASE;
          q_nxt.cnt      = PAGE_LOAD;
          q_nxt.cfg_pend = 1'b1;
        end else if (erase_go && PAGE_ERASE_TRIGGER_I &&
                     in_range(ERASE_ADDR_I, FLASH_BASE, FLASH_SIZE)) begin
          q_nxt.st       = ST_ERASE;
          q_nxt.cmd.op   = OP_ERASE_PAGE;
          q_nxt.cmd.addr = page_of(ERASE_ADDR_I);
          q_nxt.cnt      = PAGE_LOAD;
          if (page_of(ERASE_ADDR_I) == q_r.part_addr) begin
            q_nxt.part_acc = PAGE_TOTAL;
          end
        end else if (erase_go && PARTIAL_ERASE_TRIGGER_I && PARTIAL_ERASE_DURATION_I != 7'h00 &&
                     in_range(ERASE_ADDR_I, FLASH_BASE, FLASH_SIZE)) begin
          q_nxt.st       = ST_ERASE;
          q_nxt.cmd.op   = OP_ERASE_PART;
          q_nxt.cmd.addr = page_of(ERASE_ADDR_I);
          q_nxt.cnt      = part_load - 32'h0000_0001;
          // accumulation restarts when software moves to another page
          if (page_of(ERASE_ADDR_I) != q_r.part_addr || q_r.part_acc >= PAGE_TOTAL) begin
            q_nxt.part_acc = part_load;
          end else begin
            q_nxt.part_acc = q_r.part_acc + part_load;
          end
          q_nxt.part_addr = page_of(ERASE_ADDR_I);
        end
      end
      ST_PRG_RD: begin
        q_nxt.st        = ST_PRG;
        q_nxt.cmd.op    = OP_PROGRAM;
        q_nxt.cmd.wdata = ARRAY_RDATA_I & q_r.cmd.wdata;
        q_nxt.cnt       = WRITE_LOAD;
      end
      ST_PRG, ST_ERASE: begin
        if (q_r.cnt == 32'h0000_0000) begin
          q_nxt.st     = ST_IDLE;
          q_nxt.cmd.op = OP_NONE;
        end else begin
          q_nxt.cnt = q_r.cnt - 32'h0000_0001;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '{st: ST_IDLE, cmd: '{op: OP_NONE, addr: 32'h0000_0000, wdata: 32'h0000_0000},
               cnt: 32'h0000_0000, fault: 1'b0, cfg_pend: 1'b0,
               part_addr: 32'hFFFF_FFFF, part_acc: 32'h0000_0000};
    end else begin
      q_r <= q_nxt;
    end
  end

  // a full program blocks the whole bus; erases only hold off flash fetches
  always_comb begin
    STORE_READY_O      = (q_r.st == ST_IDLE);
    BUS_STALL_O        = (q_r.st == ST_PRG_RD) || (q_r.st == ST_PRG) ||
                         ((q_r.st == ST_ERASE) && FETCH_FLASH_I);
    READY_O            = (q_r.st == ST_IDLE);
    ARRAY_CMD_O        = q_r.cmd;
    HARD_FAULT_O       = q_r.fault;
    USER_CFG_PENDING_O = q_r.cfg_pend;
    PARTIAL_COMPLETE_O = (q_r.part_acc >= PAGE_TOTAL);
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!rst_n);

  property p_prog_and;
    (q_r.st == ST_PRG_RD) |=> (ARRAY_CMD_O.op == OP_PROGRAM) && (ARRAY_CMD_O.wdata == $past(ARRAY_RDATA_I & q_r.cmd.wdata));
  endproperty
  a_prog_and: assert property (p_prog_and) else $error("programmed word is not old AND new");

  property p_prog_len;
    (q_r.st == ST_PRG_RD) |=> (q_r.cnt == WRITE_LOAD) && BUS_STALL_O;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("word program length or stall wrong");

  property p_fault;
    (q_r.st == ST_IDLE && STORE_VALID_I && store_target && STORE_REQ_I.size != SIZE_WORD)
      |=> HARD_FAULT_O && (q_r.st == ST_IDLE);
  endproperty
  a_fault: assert property (p_fault) else $error("narrow store not faulted");

  property p_ro_ignored;
    (q_r.st == ST_IDLE && STORE_VALID_I && ACCESS_MODE_I == MODE_READ_ONLY) |=> (ARRAY_CMD_O.op == OP_NONE);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("read only store reached the array");

  property p_erase_stall;
    (q_r.st == ST_ERASE) |-> (BUS_STALL_O == FETCH_FLASH_I);
  endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("erase stall not tied to flash fetch");

  property p_page_erase;
    (erase_go && PAGE_ERASE_TRIGGER_I && !FULL_ERASE_TRIGGER_I && !USER_AREA_ERASE_TRIGGER_I && !STORE_VALID_I &&
     in_range(ERASE_ADDR_I, FLASH_BASE, FLASH_SIZE))
      |=> (ARRAY_CMD_O.op == OP_ERASE_PAGE) && (q_r.cnt == PAGE_LOAD) && !READY_O;
  endproperty
  a_page_erase: assert property (p_page_erase) else $error("page erase not started");

  property p_partial_user;
    (erase_go && PARTIAL_ERASE_TRIGGER_I && in_range(ERASE_ADDR_I, USER_AREA_BASE, USER_AREA_SIZE)
     && !PAGE_ERASE_TRIGGER_I && !FULL_ERASE_TRIGGER_I && !USER_AREA_ERASE_TRIGGER_I && !STORE_VALID_I)
      |=> READY_O;
  endproperty
  a_partial_user: assert property (p_partial_user) else $error("partial erase touched user area");

  property p_ready;
    (q_r.st != ST_IDLE) && (q_r.cnt != 32'h0000_0000) |=> !READY_O [*1] ##1 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("ready high during operation");

  property p_full_erase;
    (erase_go && FULL_ERASE_TRIGGER_I && !STORE_VALID_I)
      |=> (ARRAY_CMD_O.op == OP_ERASE_ALL) && (q_r.cnt == FULL_LOAD) && USER_CFG_PENDING_O;
  endproperty
  a_full_erase: assert property (p_full_erase) else $error("full erase not started");

  c_program:  cover property ((q_r.st == ST_PRG) && (q_r.cnt == 32'h0000_0000));
  c_partial:  cover property ((ARRAY_CMD_O.op == OP_ERASE_PART) && FETCH_FLASH_I);
  c_fault:    cover property (HARD_FAULT_O);
  c_user_era: cover property (ARRAY_CMD_O.op == OP_ERASE_USER);

endmodule : nonvolatile_controller

// >>> shared/nvm_ctrl_pkg.sv
// constants, types and state carriers for the flash write and erase sequencer
package nvm_ctrl_pkg;

  localparam int unsigned CLK_PERIOD_NS       = 50;
  localparam int unsigned WORD_WRITE_TIME_US  = 41;
  localparam int unsigned PAGE_ERASE_TIME_US  = 85000;
  localparam int unsigned FULL_ERASE_TIME_US  = 85000;
  localparam int unsigned PARTIAL_UNIT_US     = 1000;
  localparam int unsigned WORD_WRITE_CYC      = (WORD_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAGE_ERASE_CYC      = (PAGE_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FULL_ERASE_CYC      = (FULL_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PARTIAL_UNIT_CYC    = (PARTIAL_UNIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [31:0] FLASH_BASE          = 32'h0000_0000;
  localparam logic [31:0] FLASH_SIZE          = 32'h0003_0000;
  localparam logic [31:0] USER_AREA_BASE      = 32'h1000_1000;
  localparam logic [31:0] USER_AREA_SIZE      = 32'h0000_1000;

  typedef enum logic [1:0] {
    MODE_READ_ONLY = 2'b00,
    MODE_PROGRAM   = 2'b01,
    MODE_ERASE     = 2'b10,
    MODE_ILLEGAL   = 2'b11
  } access_mode_e;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10,
    SIZE_RSVD = 2'b11
  } store_size_e;

  typedef enum logic [2:0] {
    OP_NONE       = 3'b000,
    OP_READ       = 3'b001,
    OP_PROGRAM    = 3'b010,
    OP_ERASE_PAGE = 3'b011,
    OP_ERASE_USER = 3'b100,
    OP_ERASE_ALL  = 3'b101,
    OP_ERASE_PART = 3'b110
  } array_op_e;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PRG_RD  = 2'b01,
    ST_PRG     = 2'b10,
    ST_ERASE   = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    store_size_e size;
  } store_req_s;

  typedef struct packed {
    array_op_e   op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } array_cmd_s;

endpackage : nvm_ctrl_pkg

// >>> tb/flash_array_model.sv
// behavioural flash array behind the sequencer's command port
`timescale 1ns/1ns
module flash_array_model #(
  parameter int unsigned PAGE_CYC = 20
) (
  input  wire logic                     clk_i,
  input  wire nvm_ctrl_pkg::array_cmd_s cmd_i,
  output logic [31:0]                   rdata_o
);
  import nvm_ctrl_pkg::*;
  logic [31:0] mem [logic [31:0]];
  int unsigned acc [logic [31:0]];
  logic [31:0] junk = 32'h5A5A_A5A5;
  logic [31:0] pg;
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'hFFFF_FFFF;
  endfunction : peek
  // erased cells read as ones, so erasing overwrites every known word in the erased range
  task automatic wipe(input logic [31:0] base, input logic [31:0] mask);
    foreach (mem[a]) if ((a & mask) == base) mem[a] = 32'hFFFF_FFFF;
  endtask : wipe
  assign pg = cmd_i.addr & 32'hFFFF_F000;
  // stale data would hide a late sample, so outside a read the bus toggles
  assign rdata_o = (cmd_i.op == OP_READ) ? peek(cmd_i.addr) : junk;
  always @(posedge clk_i) begin
    junk <= ~junk;
    case (cmd_i.op)
      OP_PROGRAM:    mem[cmd_i.addr] = peek(cmd_i.addr) & cmd_i.wdata;
      OP_ERASE_PAGE: wipe(pg, 32'hFFFF_F000);
      OP_ERASE_USER: wipe(USER_AREA_BASE, 32'hFFFF_F000);
      OP_ERASE_ALL:  wipe(32'h0, 32'h0);
      OP_ERASE_PART: begin
        acc[pg] = acc.exists(pg) ? acc[pg] + 1 : 1;
        if (acc[pg] >= PAGE_CYC) begin
          wipe(pg, 32'hFFFF_F000);
          acc[pg] = 0;
        end
      end
      default: ;
    endcase
  end
endmodule : flash_array_model

// >>> tb/test_nonvolatile_controller.sv
// self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ns
module test_nonvolatile_controller;
  import nvm_ctrl_pkg::*;
  localparam int unsigned PG = 20;
  localparam int unsigned FL = 30;
  localparam int unsigned PU = 4;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  access_mode_e mode = MODE_READ_ONLY;
  logic         valid = 1'b0;
  store_req_s   req = '0;
  logic         fetch = 1'b0;
  logic         fe_trg = 1'b0;
  logic         ua_trg = 1'b0;
  logic         pg_trg = 1'b0;
  logic         pe_trg = 1'b0;
  logic [31:0]  eaddr = 32'h0;
  logic [6:0]   dur = 7'h0;
  logic [31:0]  rdata;
  array_cmd_s   cmd;
  logic         s_rdy, stall, fault, rdy, pend, pdone;
  int           failures = 0;
  int           compares = 0;

  nonvolatile_controller #(.PAGE_ERASE_CYCLES(PG), .FULL_ERASE_CYCLES(FL), .PARTIAL_UNIT_CYCLES(PU)) dut (
    .MCLK_I(clk), .RESET_N_I(rst_n), .ACCESS_MODE_I(mode), .STORE_VALID_I(valid), .STORE_REQ_I(req),
    .STORE_READY_O(s_rdy), .FETCH_FLASH_I(fetch), .PAGE_ERASE_TRIGGER_I(pg_trg),
    .USER_AREA_ERASE_TRIGGER_I(ua_trg), .FULL_ERASE_TRIGGER_I(fe_trg), .PARTIAL_ERASE_TRIGGER_I(pe_trg),
    .ERASE_ADDR_I(eaddr), .PARTIAL_ERASE_DURATION_I(dur), .ARRAY_RDATA_I(rdata), .ARRAY_CMD_O(cmd),
    .BUS_STALL_O(stall), .HARD_FAULT_O(fault), .READY_O(rdy), .USER_CFG_PENDING_O(pend),
    .PARTIAL_COMPLETE_O(pdone));

  flash_array_model #(.PAGE_CYC(PG)) u_arr (.clk_i(clk), .cmd_i(cmd), .rdata_o(rdata));

  initial forever #25 clk = ~clk;

  task automatic report_and_stop();
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // counts busy cycles and fault pulses; erase runs toggle the fetch input to probe the stall
  task automatic settle(input bit fw, output int n, output int f);
    int k;
    n = 0;
    f = 0;
    k = 0;
    do begin
      @(negedge clk);
      valid = 1'b0;
      {fe_trg, ua_trg, pg_trg, pe_trg} = 4'h0;
      fetch = fw && (k % 2 == 1);
      #1;
      k++;
      f += (fault === 1'b1);
      if (rdy !== 1'b1) n++;
      chk(32'(stall), 32'((rdy !== 1'b1) ? (fw ? fetch : 1'b1) : 1'b0));
    end while ((k < 3 || rdy !== 1'b1) && k < 2000);
    fetch = 1'b0;
    if (k >= 2000) begin
      failures++;
      report_and_stop();
    end
  endtask : settle

  task automatic store(input access_mode_e m, input logic [31:0] a, input logic [31:0] d,
                       input store_size_e s, input int en, input int ef);
    int n, f;
    @(negedge clk);
    mode = m;
    req = '{a, d, s};
    valid = 1'b1;
    settle(1'b0, n, f);
    chk(32'(n), 32'(en));
    chk(32'(f), 32'(ef));
  endtask : store

  // trigger bits: 3 full, 2 user area, 1 page, 0 partial
  task automatic erase(input access_mode_e m, input logic [3:0] t, input logic [31:0] a,
                       input logic [6:0] d, input int lo);
    int n, f;
    @(negedge clk);
    mode = m;
    {fe_trg, ua_trg, pg_trg, pe_trg} = t;
    eaddr = a;
    dur = d;
    settle(1'b1, n, f);
    chk(32'(n), 32'(lo));
  endtask : erase

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'({rdy, s_rdy, stall, fault, pend, pdone}), 32'h30);
    store(MODE_PROGRAM, 32'h100, 32'hFFFF_00FF, SIZE_WORD, WORD_WRITE_CYC + 1, 0);
    chk(u_arr.peek(32'h100), 32'hFFFF_00FF);
    store(MODE_PROGRAM, 32'h100, 32'h0F0F_0F0F, SIZE_WORD, WORD_WRITE_CYC + 1, 0);
    chk(u_arr.peek(32'h100), 32'h0F0F_000F);
    store(MODE_PROGRAM, 32'h104, 32'h0, SIZE_BYTE, 0, 1);
    store(MODE_PROGRAM, 32'h104, 32'h0, SIZE_HALF, 0, 1);
    store(MODE_PROGRAM, 32'h102, 32'h0, SIZE_WORD, 0, 1);
    store(MODE_READ_ONLY, 32'h104, 32'h0, SIZE_WORD, 0, 0);
    store(MODE_ERASE, 32'h104, 32'h0, SIZE_WORD, 0, 0);
    store(MODE_ILLEGAL, 32'h104, 32'h0, SIZE_WORD, 0, 0);
    chk(u_arr.peek(32'h104), 32'hFFFF_FFFF);
    store(MODE_PROGRAM, USER_AREA_BASE, 32'h1234_5678, SIZE_WORD, WORD_WRITE_CYC + 1, 0);
    chk(32'(pend), 32'h1);
    chk(u_arr.peek(USER_AREA_BASE), 32'h1234_5678);
    erase(MODE_PROGRAM, 4'h4, 32'h0, 7'h0, 0);
    erase(MODE_ILLEGAL, 4'h2, 32'h104, 7'h0, 0);
    erase(MODE_ERASE, 4'h4, 32'h0, 7'h0, PG);
    chk(u_arr.peek(USER_AREA_BASE), 32'hFFFF_FFFF);
    chk(u_arr.peek(32'h100), 32'h0F0F_000F);
    erase(MODE_ERASE, 4'h2, 32'h104, 7'h0, PG);
    chk(u_arr.peek(32'h100), 32'hFFFF_FFFF);
    store(MODE_PROGRAM, 32'h100, 32'h0, SIZE_WORD, WORD_WRITE_CYC + 1, 0);
    erase(MODE_ERASE, 4'h1, 32'h104, 7'h0, 0);
    erase(MODE_ERASE, 4'h1, USER_AREA_BASE, 7'h2, 0);
    repeat (3) erase(MODE_ERASE, 4'h1, 32'h104, 7'h2, 2 * PU);
    chk(32'(pdone), 32'h1);
    chk(u_arr.peek(32'h100), 32'hFFFF_FFFF);
    store(MODE_PROGRAM, 32'h200, 32'h0, SIZE_WORD, WORD_WRITE_CYC + 1, 0);
    erase(MODE_ERASE, 4'h8, 32'h0, 7'h0, FL);
    chk(u_arr.peek(32'h200), 32'hFFFF_FFFF);
    chk(32'(pdone), 32'h0);
    chk(32'(pend), 32'h1);
    // mid-run reset: pending user configuration is taken up and cleared
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(32'({rdy, stall, fault, pend}), 32'h8);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'({rdy, s_rdy, stall, fault, pend, pdone}), 32'h30);
    report_and_stop();
  end
endmodule : test_nonvolatile_controller
